/* File: include/bitop_consts.svh */
// Purpose: Constants for the bit-manipulation datapath
// Assumes: Byte operands, 3-bit bit numbers
// Notes:   Definitions only
`ifndef BITOP_CONSTS_SVH
`define BITOP_CONSTS_SVH

`define BIT_NUM_W    3
`define OPND_W       8
`define FLAG_RESET   1'b0
`define BYTE_RESET   8'h00

`endif

/* File: include/bitop_pkg.sv */
// Purpose: Types for the bit-manipulation datapath
// Assumes: bitop_consts.svh on the include path
// Notes:   Operation codes carry no fixed encoding
`default_nettype none
`include "bitop_consts.svh"

package bitop_pkg;

    // Operations of the unit
    typedef enum logic [3:0] {
        set_bit_op,
        clear_bit_op,
        invert_bit_op,
        test_bit_op,
        carry_and_bit_op,
        carry_and_inverted_bit_op,
        carry_or_bit_op,
        carry_or_inverted_bit_op,
        carry_xor_bit_op,
        carry_xor_inverted_bit_op,
        load_bit_to_carry_op,
        load_inverted_bit_to_carry_op,
        store_carry_to_bit_op,
        store_inverted_carry_to_bit_op
    } bit_op_t;

    // One request from the instruction decoder
    typedef struct packed {
        bit_op_t                   op;
        logic                      use_reg;   // Bit number from register
        logic [`BIT_NUM_W-1:0]     imm_bit;
        logic [`OPND_W-1:0]        bit_reg;   // Register holding bit number
        logic                      to_mem;    // Operand lives in memory
        logic [15:0]               addr;
        logic [`OPND_W-1:0]        opnd;      // Register operand value
    } bit_req_t;

    // Result returned to the core
    typedef struct packed {
        logic                      write_reg; // Register byte to write back
        logic [`OPND_W-1:0]        data;
        logic                      carry;
        logic                      zero;
        logic                      illegal;   // Register bit number refused
    } bit_rsp_t;

endpackage

`default_nettype wire

/* File: hw/bit_manip_unit.sv */
// Purpose: Bit-manipulation datapath of an 8-bit CPU core
// Assumes: Inputs synchronous to clk; memory answers rd_data on rd_ack
// Notes:   One request at a time; busy is high until done
`include "bitop_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module bit_manip_unit (
    input  wire logic                 clk,      // CPU clock, 20 MHz
    input  wire logic                 rst_b,    // Async reset, active low
    input  wire logic                 clk_en,   // Freezes state when low
    input  wire logic                 start,    // Request strobe
    input  wire bitop_pkg::bit_req_t  req,      // Request fields
    input  wire logic                 carry_in, // Current carry flag
    input  wire logic                 zero_in,  // Current zero flag
    output logic                      busy,     // Request in progress
    output logic                      done,     // Result valid pulse
    output bitop_pkg::bit_rsp_t       rsp,      // Result, registered
    output logic                      rd_req,   // Memory read request
    input  wire logic                 rd_ack,   // Memory read data valid
    input  wire logic [7:0]           rd_data,  // Memory read data
    output logic                      wr_req,   // Memory write strobe
    output logic [15:0]               mem_addr, // Memory address
    output logic [7:0]                wr_data   // Memory write data
);
    import bitop_pkg::*;

    // ------------------------------------------------------------
    // Operation classes
    // ------------------------------------------------------------
    function automatic logic op_inverted(input bit_op_t o);
        case (o)
            carry_and_inverted_bit_op, carry_or_inverted_bit_op,
            carry_xor_inverted_bit_op, load_inverted_bit_to_carry_op,
            store_inverted_carry_to_bit_op: op_inverted = 1'b1;
            default: op_inverted = 1'b0;
        endcase
    endfunction

    function automatic logic op_writes(input bit_op_t o);
        case (o)
            set_bit_op, clear_bit_op, invert_bit_op,
            store_carry_to_bit_op,
            store_inverted_carry_to_bit_op: op_writes = 1'b1;
            default: op_writes = 1'b0;
        endcase
    endfunction

    // New byte value for a modifying operation
    function automatic logic [7:0] modify(input bit_op_t o,
                                          input logic [7:0] b,
                                          input logic [2:0] n,
                                          input logic c);
        logic [7:0] r;
        r = b;
        case (o)
            set_bit_op:                     r[n] = 1'b1;
            clear_bit_op:                   r[n] = 1'b0;
            invert_bit_op:                  r[n] = ~b[n];
            store_carry_to_bit_op:          r[n] = c;
            store_inverted_carry_to_bit_op: r[n] = ~c;
            default:                        r = b;
        endcase
        return r;
    endfunction

    // New carry for a carry operation
    function automatic logic new_carry(input bit_op_t o, input logic c,
                                       input logic b);
        case (o)
            carry_and_bit_op:              new_carry = c & b;
            carry_and_inverted_bit_op:     new_carry = c & ~b;
            carry_or_bit_op:               new_carry = c | b;
            carry_or_inverted_bit_op:      new_carry = c | ~b;
            carry_xor_bit_op:              new_carry = c ^ b;
            carry_xor_inverted_bit_op:     new_carry = c ^ ~b;
            load_bit_to_carry_op:          new_carry = b;
            load_inverted_bit_to_carry_op: new_carry = ~b;
            default:                       new_carry = c;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Request capture and bit selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {st_idle, st_read, st_exec} state_t;

    state_t                 state_q;
    bit_req_t               req_q;
    logic                   c_q;
    logic                   z_q;
    logic [7:0]             byte_q;
    logic [`BIT_NUM_W-1:0]  bitn;
    logic                   refuse;
    logic                   sel;

    assign bitn = req_q.use_reg ? req_q.bit_reg[`BIT_NUM_W-1:0]
                                : req_q.imm_bit;
    // register source refused for inverted ops
    assign refuse = req_q.use_reg && op_inverted(req_q.op);
    assign sel    = byte_q[bitn];
    assign busy   = (state_q != st_idle);
    assign rd_req = (state_q == st_read);

    // Sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= st_idle;
        end else if (clk_en) begin
            case (state_q)
                st_idle: begin
                    if (start) begin
                        state_q <= req.to_mem ? st_read : st_exec;
                    end
                end
                st_read: begin
                    if (rd_ack) begin
                        state_q <= st_exec;
                    end
                end
                st_exec: state_q <= st_idle;
                default: state_q <= st_idle;
            endcase
        end
    end

    // Operand and flag capture
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q  <= '0;
            c_q    <= `FLAG_RESET;
            z_q    <= `FLAG_RESET;
            byte_q <= `BYTE_RESET;
        end else if (clk_en) begin
            if (state_q == st_idle && start) begin
                req_q  <= req;
                c_q    <= carry_in;
                z_q    <= zero_in;
                byte_q <= req.opnd;
            end else if (state_q == st_read && rd_ack) begin
                byte_q <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // Result and write-back
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp      <= '0;
            done     <= 1'b0;
            wr_req   <= 1'b0;
            mem_addr <= 16'h0000;
            wr_data  <= `BYTE_RESET;
        end else if (clk_en) begin
            done   <= 1'b0;
            wr_req <= 1'b0;
            if (state_q == st_idle && start) begin
                mem_addr <= req.addr;
            end
            if (state_q == st_exec) begin
                done        <= 1'b1;
                rsp.illegal <= refuse;
                rsp.carry   <= c_q;
                rsp.zero    <= z_q;
                rsp.data    <= byte_q;
                rsp.write_reg <= 1'b0;
                if (!refuse) begin
                    rsp.carry <= new_carry(req_q.op, c_q, sel);
                    if (req_q.op == test_bit_op) begin
                        rsp.zero <= ~sel;
                    end
                    if (op_writes(req_q.op)) begin
                        rsp.data <= modify(req_q.op, byte_q, bitn, c_q);
                        rsp.write_reg <= !req_q.to_mem;
                        // full byte back to same address
                        if (req_q.to_mem) begin
                            wr_req  <= 1'b1;
                            wr_data <= modify(req_q.op, byte_q, bitn, c_q);
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_test_zero_flag: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == test_bit_op)
        |=> (rsp.zero == ~$past(sel)) && rsp.data == $past(byte_q))
        else $error("test op zero flag wrong");

    a_set_bit_one: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == set_bit_op)
        |=> rsp.data == ($past(byte_q) | (8'h01 << $past(bitn))))
        else $error("set op result wrong");

    a_clear_bit_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == clear_bit_op)
        |=> rsp.data == ($past(byte_q) & ~(8'h01 << $past(bitn))))
        else $error("clear op result wrong");

    a_invert_bit_flip: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == invert_bit_op)
        |=> rsp.data == ($past(byte_q) ^ (8'h01 << $past(bitn))))
        else $error("invert op result wrong");

    a_and_carry_result: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == carry_and_bit_op)
        |=> rsp.carry == ($past(c_q) & $past(sel)))
        else $error("carry and wrong");

    a_load_inv_carry: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == load_inverted_bit_to_carry_op)
        |=> rsp.carry == ~$past(sel))
        else $error("inverted load wrong");

    a_inv_reg_refused: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && refuse)
        |=> rsp.illegal && !wr_req && rsp.carry == $past(c_q))
        else $error("register bit number not refused");

    a_mem_write_back: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_read && rd_ack && op_writes(req_q.op)
            && !refuse)
        |=> (clk_en ##1 wr_req && mem_addr == req_q.addr) or !clk_en)
        else $error("memory byte not written back");

    a_store_keeps_zero: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && req_q.op != test_bit_op)
        |=> rsp.zero == $past(z_q))
        else $error("zero flag disturbed");

    a_store_carry_bit: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == store_carry_to_bit_op)
        |=> rsp.data == (($past(byte_q) & ~(8'h01 << $past(bitn)))
            | (8'($past(c_q)) << $past(bitn))))
        else $error("carry store result wrong");

    a_or_inv_carry: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && state_q == st_exec && !refuse
            && req_q.op == carry_or_inverted_bit_op)
        |=> rsp.carry == ($past(c_q) | ~$past(sel)))
        else $error("inverted carry or wrong");

    c_mem_rmw: cover property (@(posedge clk) disable iff (!rst_b)
        wr_req);
    c_reg_test: cover property (@(posedge clk) disable iff (!rst_b)
        done && !rsp.illegal && req_q.op == test_bit_op);
    c_refused: cover property (@(posedge clk) disable iff (!rst_b)
        done && rsp.illegal);
    c_frozen_busy: cover property (@(posedge clk) disable iff (!rst_b)
        busy && !clk_en);
    c_read_stall: cover property (@(posedge clk) disable iff (!rst_b)
        rd_req && !rd_ack ##1 rd_req && rd_ack);

endmodule

`default_nettype wire

/* File: tb/bit_manip_unit_tb.sv */
// Purpose: Self-checking bench for the bit-manipulation datapath
// Assumes: Bench answers memory reads itself, no partner model
// Notes:   Expected results come from the bench's own model
`timescale 1ns/10ps
`default_nettype none

module bit_manip_unit_tb;
    import bitop_pkg::*;

    logic       clk;
    logic       rst_b;
    logic       clk_en;
    logic       start;
    bit_req_t   req;
    logic       carry_in;
    logic       zero_in;
    logic       rd_ack;
    logic [7:0] rd_data;
    logic       busy;
    logic       done;
    bit_rsp_t   rsp;
    logic       rd_req;
    logic       wr_req;
    logic [15:0] mem_addr;
    logic [7:0] wr_data;
    int         error_cnt;
    int         cmp_count;

    bit_manip_unit bit_manip_unit_i (
        .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .start(start),
        .req(req), .carry_in(carry_in), .zero_in(zero_in),
        .busy(busy), .done(done), .rsp(rsp), .rd_req(rd_req),
        .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
        .mem_addr(mem_addr), .wr_data(wr_data));

    // Clock at 20 MHz
    always #25 clk = ~clk;

    // ------------------------------------------------
    // Checking and closing
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic is_inv(input bit_op_t op);
        return op inside {carry_and_inverted_bit_op, carry_or_inverted_bit_op,
            carry_xor_inverted_bit_op, load_inverted_bit_to_carry_op,
            store_inverted_carry_to_bit_op};
    endfunction

    // ------------------------------------------------
    // One operation: drive, answer memory, judge
    // ------------------------------------------------
    task automatic run_op(input bit_op_t op, input logic use_reg,
                          input logic [2:0] n, input logic mem,
                          input logic [7:0] opnd, input logic cin,
                          input logic zin, input int stall,
                          input logic freeze);
        logic [7:0]  d;
        logic [15:0] addr;
        logic        b;
        logic        c;
        logic        z;
        logic        wr;
        logic        ill;
        logic        seen;
        int          lat;
        d = opnd;
        b = opnd[n];
        c = cin;
        z = zin;
        wr = 1'b0;
        addr = {12'h3c0, 4'(op)};
        ill = use_reg && is_inv(op);
        if (!ill) begin
            case (op)
                set_bit_op:                     begin d[n] = 1'b1; wr = 1; end
                clear_bit_op:                   begin d[n] = 1'b0; wr = 1; end
                invert_bit_op:                  begin d[n] = ~b; wr = 1; end
                test_bit_op:                    z = ~b;
                carry_and_bit_op:               c = cin & b;
                carry_and_inverted_bit_op:      c = cin & ~b;
                carry_or_bit_op:                c = cin | b;
                carry_or_inverted_bit_op:       c = cin | ~b;
                carry_xor_bit_op:               c = cin ^ b;
                carry_xor_inverted_bit_op:      c = cin ^ ~b;
                load_bit_to_carry_op:           c = b;
                load_inverted_bit_to_carry_op:  c = ~b;
                store_carry_to_bit_op:          begin d[n] = cin; wr = 1; end
                default:                        begin d[n] = ~cin; wr = 1; end
            endcase
        end
        @(posedge clk);
        start <= 1'b1;
        req.op <= op;
        req.use_reg <= use_reg;
        req.imm_bit <= use_reg ? ~n : n;
        req.bit_reg <= {5'h16, use_reg ? n : ~n};
        req.to_mem <= mem;
        req.addr <= addr;
        req.opnd <= mem ? ~opnd : opnd;
        carry_in <= cin;
        zero_in <= zin;
        @(posedge clk);
        start <= 1'b0;
        req.opnd <= ~opnd;
        req.addr <= ~addr;
        carry_in <= ~cin;
        zero_in <= ~zin;
        if (freeze) begin
            clk_en <= 1'b0;
            repeat (4) begin
                @(negedge clk);
                check("busy frozen", 16'(busy), 16'h0001);
                check("done frozen", 16'(done), 16'h0000);
            end
            @(posedge clk);
            clk_en <= 1'b1;
        end
        seen = 1'b0;
        lat = 0;
        while (!seen && lat < 40) begin
            @(negedge clk);
            lat++;
            if (lat == 1 && !freeze)
                check("busy", 16'(busy), 16'h0001);
            if (done === 1'b1)
                seen = 1'b1;
            else if (mem && rd_req === 1'b1) begin
                if (stall > 0)
                    stall--;
                else begin
                    @(posedge clk);
                    rd_ack <= 1'b1;
                    rd_data <= opnd;
                    @(posedge clk);
                    rd_ack <= 1'b0;
                    rd_data <= ~opnd;
                end
            end
        end
        check("done seen", 16'(seen), 16'h0001);
        check("illegal", 16'(rsp.illegal), 16'(ill));
        check("carry", 16'(rsp.carry), 16'(c));
        check("zero", 16'(rsp.zero), 16'(z));
        check("data", 16'(rsp.data), 16'(d));
        if (!mem) begin
            check("wr_req reg", 16'(wr_req), 16'h0000);
            check("write_reg", 16'(rsp.write_reg), 16'(wr));
        end else begin
            check("write_reg mem", 16'(rsp.write_reg), 16'h0000);
            check("wr_req", 16'(wr_req), 16'(wr));
            if (wr) begin
                check("wr_data", 16'(wr_data), 16'(d));
                check("mem_addr", mem_addr, addr);
            end
        end
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic test_reg_ops;
        for (int k = 0; k < 14; k++) begin
            for (int u = 0; u < 2; u++) begin
                if (!(u == 1 && is_inv(bit_op_t'(k))))
                    run_op(bit_op_t'(k), 1'(u), 3'(k + u * 3), 1'b0,
                           8'h5a ^ 8'(k * 17), 1'(k ^ u), 1'(k >> 1), 0,
                           1'b0);
            end
        end
        $display("register operand test finished");
    endtask

    task automatic test_illegal;
        for (int k = 0; k < 14; k++) begin
            if (is_inv(bit_op_t'(k)))
                run_op(bit_op_t'(k), 1'b1, 3'(k), 1'b0, 8'hc3, 1'(k),
                       1'(~k), 0, 1'b0);
        end
        $display("register bit number refusal test finished");
    endtask

    task automatic test_mem_ops;
        for (int k = 0; k < 14; k++)
            run_op(bit_op_t'(k), 1'b0, 3'(7 - k), 1'b1, 8'h96 ^ 8'(k),
                   1'(~k), 1'(k), k % 3, 1'b0);
        $display("memory operand test finished");
    endtask

    task automatic test_freeze;
        run_op(invert_bit_op, 1'b0, 3'h7, 1'b0, 8'h0f, 1'b1, 1'b0, 0,
               1'b1);
        run_op(store_inverted_carry_to_bit_op, 1'b0, 3'h0, 1'b1, 8'hff,
               1'b1, 1'b1, 1, 1'b1);
        $display("clock enable freeze test finished");
    endtask

    // Reset hits while a memory read is pending, then one clean op
    task automatic test_reset;
        @(posedge clk);
        start <= 1'b1;
        req.op <= set_bit_op;
        req.use_reg <= 1'b0;
        req.to_mem <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        check("rd_req pending", 16'(rd_req), 16'h0001);
        @(posedge clk);
        rst_b <= 1'b0;
        @(negedge clk);
        check("busy in reset", 16'(busy), 16'h0000);
        check("rd_req in reset", 16'(rd_req), 16'h0000);
        check("rsp in reset", 16'(rsp), 16'h0000);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        run_op(set_bit_op, 1'b0, 3'h2, 1'b1, 8'h00, 1'b0, 1'b1, 0, 1'b0);
        $display("mid-run reset test finished");
    endtask

    // Main sequence
    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        clk_en = 1'b1;
        start = 1'b0;
        req = '0;
        carry_in = 1'b0;
        zero_in = 1'b0;
        rd_ack = 1'b0;
        rd_data = 8'h00;
        error_cnt = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        check("busy reset", 16'(busy), 16'h0000);
        check("done reset", 16'(done), 16'h0000);
        test_reg_ops;
        test_illegal;
        test_mem_ops;
        test_freeze;
        test_reset;
        complete_run;
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #250000;
        error_cnt++;
        complete_run;
    end
endmodule

`default_nettype wire
